// ### hdl/tsr_sensor_bank.sv
// Register bank, pointer decode and conversion sequencer of the temperature sensor
`timescale 1ns/100ps
`include "tsr_defs.svh"

// Behaviour
// - Result stored 12-bit left-justified, 1C/0.0625C
// - Result at pointer 0, read-only, resets 0000
// - Shutdown and one-shot clear means continuous
// - One-shot mode: write starts single conversion
// - Shutdown set: one-shot writes do nothing
// - Fault queue codes give 1,2,4,6 faults
// - Polarity bit picks alert active level
// - Style bit picks comparator or interrupt
// - Shutdown bit set stops conversions
// - Settings at pointer 1, low byte zero
// - Low limit at pointer 2, resets 4b00
// - Low limit 12-bit, low nibble reads zero
// - High limit at pointer 3, resets 5000
// - High limit 12-bit, low nibble reads zero
// - Pin-selected bus address, eight devices
// - Three pointer LSBs select target register
// - Pointer 4 write requests one conversion
// - Shutdown aborts conversion, clears alert, faults
// - Continuous: 80 ms period, 27 ms conversion
module tsr_sensor_bank #(
	parameter int         CONV_CYCLES   = `TSR_CONV_TIME_MS * `TSR_CLK_KHZ, // Conversion length
	parameter int         PERIOD_CYCLES = `TSR_PERIOD_MS * `TSR_CLK_KHZ,    // Start to start
	parameter int         CNT_W         = 24,                               // Timer width
	parameter logic [3:0] ADDR_BASE     = 4'h5                              // Arbitrary value
) (
	input  wire logic        mclk_i,        // System clock, 100 MHz
	input  wire logic        rst_i,         // Synchronous reset, high
	input  wire logic        ce_i,          // Clock enable, freezes all state
	input  wire logic [2:0]  addr_pin_i,    // Address strap pins
	input  wire logic        ptr_wr_i,      // Pointer byte strobe
	input  wire logic [7:0]  ptr_data_i,    // Pointer byte
	input  wire logic        reg_wr_i,      // Data word write strobe
	input  wire logic [15:0] wr_data_i,     // Data word to write
	input  wire logic        reg_rd_i,      // Data word read strobe
	input  wire logic [11:0] sample_i,      // Converter output code
	output logic [15:0]      rd_data_o,     // Read data word
	output logic             rd_valid_o,    // Read data present
	output logic [6:0]       dev_addr_o,    // Bus address answered
	output logic             conv_active_o, // Conversion in progress
	output logic             alert_o,       // Alert pin level
	output logic             alert_oe_o     // Alert pin drive enable
);

	// ----------------------------------------------------------------
	// Strap synchroniser
	// ----------------------------------------------------------------
	logic [2:0] addr_meta;
	logic [2:0] addr_sync;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			addr_meta  <= 3'h0;
			addr_sync  <= 3'h0;
			dev_addr_o <= 7'h00;
		end else if (ce_i) begin
			addr_meta  <= addr_pin_i;
			addr_sync  <= addr_meta;
			// Low three bits follow the pins so eight parts share a bus
			dev_addr_o <= {ADDR_BASE, addr_sync};
		end
	end

	// ----------------------------------------------------------------
	// Pointer and write decode
	// ----------------------------------------------------------------
	logic [2:0]  pointer_select_bits;
	logic        one_shot_select;
	logic [1:0]  fault_queue_depth;
	logic        alert_level_select;
	logic        alarm_style_select;
	logic        shutdown_request;
	logic [11:0] temp_result_bits;
	logic [11:0] lower_limit_bits;
	logic [11:0] upper_limit_bits;

	// A pointer byte and a data word in the same cycle: the word goes to the new pointer
	wire [2:0]  eff_ptr   = ptr_wr_i ? ptr_data_i[`TSR_PTR_MSB:`TSR_PTR_LSB]
	                                 : pointer_select_bits;
	wire        sel_temp  = (eff_ptr == `TSR_PTR_TEMP);
	wire        sel_cfg   = (eff_ptr == `TSR_PTR_CFG);
	wire        sel_low   = (eff_ptr == `TSR_PTR_LOW);
	wire        sel_high  = (eff_ptr == `TSR_PTR_HIGH);
	wire        sel_os    = (eff_ptr == `TSR_PTR_ONESHOT);
	wire        wr_cfg    = reg_wr_i && sel_cfg;
	wire        wr_low    = reg_wr_i && sel_low;
	wire        wr_high   = reg_wr_i && sel_high;
	wire        wr_os     = reg_wr_i && sel_os;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pointer_select_bits <= `TSR_PTR_TEMP;
		end else if (ce_i && ptr_wr_i) begin
			// Upper pointer bits are not stored
			pointer_select_bits <= ptr_data_i[`TSR_PTR_MSB:`TSR_PTR_LSB];
		end
	end

	// ----------------------------------------------------------------
	// Settings word
	// ----------------------------------------------------------------
	localparam logic [15:0] CFG_RST = `TSR_RST_CFG;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			one_shot_select    <= CFG_RST[`TSR_CFG_ONESHOT];
			fault_queue_depth  <= CFG_RST[`TSR_CFG_FQ_MSB:`TSR_CFG_FQ_LSB];
			alert_level_select <= CFG_RST[`TSR_CFG_POL];
			alarm_style_select <= CFG_RST[`TSR_CFG_STYLE];
			shutdown_request   <= CFG_RST[`TSR_CFG_SHUT];
		end else if (ce_i && wr_cfg) begin
			// Reserved bits are expected as zero and are dropped
			one_shot_select    <= wr_data_i[`TSR_CFG_ONESHOT];
			fault_queue_depth  <= wr_data_i[`TSR_CFG_FQ_MSB:`TSR_CFG_FQ_LSB];
			alert_level_select <= wr_data_i[`TSR_CFG_POL];
			alarm_style_select <= wr_data_i[`TSR_CFG_STYLE];
			shutdown_request   <= wr_data_i[`TSR_CFG_SHUT];
		end
	end

	// ----------------------------------------------------------------
	// Limit registers
	// ----------------------------------------------------------------
	localparam logic [15:0] LOW_RST  = `TSR_RST_LOW;
	localparam logic [15:0] HIGH_RST = `TSR_RST_HIGH;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			lower_limit_bits <= LOW_RST[`TSR_DATA_MSB:`TSR_DATA_LSB];
			upper_limit_bits <= HIGH_RST[`TSR_DATA_MSB:`TSR_DATA_LSB];
		end else if (ce_i) begin
			if (wr_low) begin
				lower_limit_bits <= wr_data_i[`TSR_DATA_MSB:`TSR_DATA_LSB];
			end
			if (wr_high) begin
				upper_limit_bits <= wr_data_i[`TSR_DATA_MSB:`TSR_DATA_LSB];
			end
		end
	end

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] CONV_LAST   = CNT_W'(CONV_CYCLES - 1);
	localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYCLES - 1);

	tsr_pkg::tsr_conv_state_type conv_state;
	tsr_pkg::tsr_conv_state_type next_conv_state;
	logic [CNT_W-1:0]            conv_cnt;
	logic [CNT_W-1:0]            next_conv_cnt;
	logic                        next_conv_done;
	logic                        result_stb;

	wire continuous_mode = !shutdown_request && !one_shot_select;
	// With shutdown set the one-shot write is ignored whatever the one-shot bit holds
	wire one_shot_go     = !shutdown_request && one_shot_select && wr_os;
	wire conv_end        = (conv_cnt == CONV_LAST);
	wire period_end      = (conv_cnt == PERIOD_LAST);
	wire [CNT_W-1:0] cnt_inc = CNT_W'(conv_cnt + 1'b1);

	always_comb begin
		next_conv_state = conv_state;
		next_conv_cnt   = conv_cnt;
		next_conv_done  = 1'b0;
		unique case (conv_state)
			tsr_pkg::CONV_SHUTDOWN: begin
				if (continuous_mode || one_shot_go) begin
					next_conv_state = tsr_pkg::CONV_RUNNING;
					next_conv_cnt   = '0;
				end
			end
			tsr_pkg::CONV_RUNNING: begin
				if (shutdown_request) begin
					// Abort: no result is written
					next_conv_state = tsr_pkg::CONV_SHUTDOWN;
					next_conv_cnt   = '0;
				end else if (conv_end) begin
					next_conv_done  = 1'b1;
					next_conv_cnt   = cnt_inc;
					next_conv_state = continuous_mode ? tsr_pkg::CONV_WAITING
					                                  : tsr_pkg::CONV_SHUTDOWN;
				end else begin
					next_conv_cnt   = cnt_inc;
				end
			end
			tsr_pkg::CONV_WAITING: begin
				if (!continuous_mode) begin
					next_conv_state = tsr_pkg::CONV_SHUTDOWN;
					next_conv_cnt   = '0;
				end else if (period_end) begin
					// Start to start spacing is the full period
					next_conv_state = tsr_pkg::CONV_RUNNING;
					next_conv_cnt   = '0;
				end else begin
					next_conv_cnt   = cnt_inc;
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			// Power-up starts a conversion at once
			conv_state    <= tsr_pkg::CONV_RUNNING;
			conv_cnt      <= '0;
			conv_active_o <= 1'b1;
			result_stb    <= 1'b0;
		end else if (ce_i) begin
			conv_state    <= next_conv_state;
			conv_cnt      <= next_conv_cnt;
			conv_active_o <= (next_conv_state == tsr_pkg::CONV_RUNNING);
			result_stb    <= next_conv_done;
		end
	end

	// ----------------------------------------------------------------
	// Result register
	// ----------------------------------------------------------------
	localparam logic [15:0] TEMP_RST = `TSR_RST_TEMP;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			temp_result_bits <= TEMP_RST[`TSR_DATA_MSB:`TSR_DATA_LSB];
		end else if (ce_i && next_conv_done) begin
			// Each result overwrites the previous one
			temp_result_bits <= sample_i;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	wire [15:0] temp_word = {temp_result_bits, `TSR_RES_BITS};
	wire [15:0] cfg_word  = {2'b00, one_shot_select, fault_queue_depth,
	                         alert_level_select, alarm_style_select,
	                         shutdown_request, 8'h00};
	wire [15:0] low_word  = {lower_limit_bits, `TSR_RES_BITS};
	wire [15:0] high_word = {upper_limit_bits, `TSR_RES_BITS};
	// One-shot code and unused codes read back as zero
	wire [15:0] rd_mux    = sel_temp ? temp_word :
	                        sel_cfg  ? cfg_word  :
	                        sel_low  ? low_word  :
	                        sel_high ? high_word : 16'h0000;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rd_data_o  <= 16'h0000;
			rd_valid_o <= 1'b0;
		end else if (ce_i) begin
			rd_valid_o <= reg_rd_i;
			if (reg_rd_i) begin
				rd_data_o <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// Alert
	// ----------------------------------------------------------------
	tsr_alert_unit alert_unit (
		.mclk_i       (mclk_i),
		.rst_i        (rst_i),
		.ce_i         (ce_i),
		.clear_i      (shutdown_request),
		.rd_ack_i     (reg_rd_i),
		.result_stb_i (result_stb),
		.result_i     (temp_result_bits),
		.upper_i      (upper_limit_bits),
		.lower_i      (lower_limit_bits),
		.depth_i      (fault_queue_depth),
		.style_i      (alarm_style_select),
		.level_i      (alert_level_select),
		.alert_o      (alert_o),
		.alert_oe_o   (alert_oe_o)
	);

endmodule

// ### pkg/tsr_defs.svh
// Offsets, field positions, reset values and timing figures of the sensor register bank
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH

// ----------------------------------------------------------------
// Pointer codes
// ----------------------------------------------------------------
`define TSR_PTR_TEMP      3'h0
`define TSR_PTR_CFG       3'h1
`define TSR_PTR_LOW       3'h2
`define TSR_PTR_HIGH      3'h3
`define TSR_PTR_ONESHOT   3'h4
`define TSR_PTR_LSB       0
`define TSR_PTR_MSB       2

// ----------------------------------------------------------------
// Settings word field positions
// ----------------------------------------------------------------
`define TSR_CFG_ONESHOT   13
`define TSR_CFG_FQ_MSB    12
`define TSR_CFG_FQ_LSB    11
`define TSR_CFG_POL       10
`define TSR_CFG_STYLE     9
`define TSR_CFG_SHUT      8

// ----------------------------------------------------------------
// Reset values and layout of 12-bit left-justified words
// ----------------------------------------------------------------
`define TSR_RST_TEMP      16'h0000
`define TSR_RST_CFG       16'h0000
`define TSR_RST_LOW       16'h4b00
`define TSR_RST_HIGH      16'h5000
`define TSR_RES_BITS      4'h0
`define TSR_DATA_MSB      15
`define TSR_DATA_LSB      4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TSR_CLK_KHZ       100000
`define TSR_CONV_TIME_MS  27
`define TSR_PERIOD_MS     80

`endif

// ### pkg/tsr_pkg.sv
// Types shared by the sensor register bank
package tsr_pkg;

	typedef enum logic [1:0] {
		CONV_SHUTDOWN,
		CONV_RUNNING,
		CONV_WAITING
	} tsr_conv_state_type;

endpackage

// ### hdl/tsr_alert_unit.sv
// Fault queue and alert pin logic of the sensor register bank
`timescale 1ns/100ps
`include "tsr_defs.svh"

module tsr_alert_unit (
	input  wire logic        mclk_i,        // System clock
	input  wire logic        rst_i,         // Synchronous reset, high
	input  wire logic        ce_i,          // Clock enable
	input  wire logic        clear_i,       // Shutdown holds alert clear
	input  wire logic        rd_ack_i,      // Host read of any register
	input  wire logic        result_stb_i,  // New result present
	input  wire logic [11:0] result_i,      // Latest result
	input  wire logic [11:0] upper_i,       // High limit
	input  wire logic [11:0] lower_i,       // Low limit
	input  wire logic [1:0]  depth_i,       // Fault queue code
	input  wire logic        style_i,       // 0 comparator, 1 interrupt
	input  wire logic        level_i,       // 0 active low, 1 active high
	output logic             alert_o,       // Alert pin level
	output logic             alert_oe_o     // Alert pin driven low
);

	function automatic logic [2:0] fault_count(input logic [1:0] code);
		unique case (code)
			2'h0: fault_count = 3'h1;
			2'h1: fault_count = 3'h2;
			2'h2: fault_count = 3'h4;
			2'h3: fault_count = 3'h6;
		endcase
	endfunction

	logic [2:0] fault_cnt;
	logic       alert_active;
	logic       hunt_high;

	wire        is_hot      = $signed(result_i) >= $signed(upper_i);
	wire        is_cold     = $signed(result_i) < $signed(lower_i);
	// Comparator tracks its own state; interrupt hunts the opposite edge after each event
	wire        watch_cmp   = alert_active ? is_cold : is_hot;
	wire        watch_int   = hunt_high ? is_hot : is_cold;
	wire        is_fault    = style_i ? watch_int : watch_cmp;
	wire [2:0]  cnt_inc     = 3'(fault_cnt + 3'h1);
	wire        trigger     = result_stb_i && is_fault && (cnt_inc >= fault_count(depth_i));
	wire        next_active = clear_i ? 1'b0 :
	                          (trigger && !style_i) ? !alert_active :
	                          (trigger && style_i) ? 1'b1 :
	                          (rd_ack_i && style_i) ? 1'b0 : alert_active;
	wire        next_level  = level_i ? next_active : !next_active;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			fault_cnt    <= 3'h0;
			alert_active <= 1'b0;
			hunt_high    <= 1'b1;
			alert_o      <= 1'b1;
			alert_oe_o   <= 1'b0;
		end else if (ce_i) begin
			if (clear_i) begin
				fault_cnt <= 3'h0;
				hunt_high <= 1'b1;
			end else if (result_stb_i) begin
				fault_cnt <= (is_fault && !trigger) ? cnt_inc : 3'h0;
				if (trigger && style_i) begin
					hunt_high <= !hunt_high;
				end
			end
			alert_active <= next_active;
			alert_o      <= next_level;
			// Open drain: only a low level is driven
			alert_oe_o   <= !next_level;
		end
	end

endmodule

// ### testbench/tsr_bank_props.sv
// Concurrent checks on the sensor register bank ports
`timescale 1ns/100ps
module tsr_bank_props #(
	parameter int CONV_CYCLES = 20 // Conversion length
) (
	input wire logic        mclk_i,        // Clock
	input wire logic        rst_i,         // Reset
	input wire logic        ce_i,          // Enable
	input wire logic        ptr_wr_i,      // Pointer strobe
	input wire logic [7:0]  ptr_data_i,    // Pointer
	input wire logic        reg_wr_i,      // Write strobe
	input wire logic [15:0] wr_data_i,     // Write word
	input wire logic        reg_rd_i,      // Read strobe
	input wire logic [15:0] rd_data_o,     // Read word
	input wire logic        rd_valid_o,    // Read valid
	input wire logic        conv_active_o, // Converting
	input wire logic        alert_o,       // Alert level
	input wire logic        alert_oe_o     // Alert drive
);
	logic [23:0] run_len;
	wire         cfg_wr = ce_i && reg_wr_i && ptr_wr_i && ptr_data_i[2:0] == 3'h1;
	wire         ptr_rd = ce_i && reg_rd_i && ptr_wr_i;
	wire         cfg_rd = ptr_rd && ptr_data_i[2:0] == 3'h1;
	wire         hi_rd  = ptr_rd && ptr_data_i[2];

	// A stuck sequencer shows as a run longer than one conversion
	always_ff @(posedge mclk_i) begin
		if (rst_i || !conv_active_o)
			run_len <= 24'h000000;
		else if (ce_i)
			run_len <= run_len + 24'h000001;
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_read_answer: assert property (ce_i && reg_rd_i |=> rd_valid_o)
		else $error("read strobe got no valid pulse");
	a_valid_cause: assert property (rd_valid_o |-> $past(ce_i && reg_rd_i))
		else $error("valid pulse without a read");
	a_nibble_zero: assert property (rd_valid_o |-> rd_data_o[3:0] == 4'h0)
		else $error("low nibble of read word not zero");
	a_cfg_reserved: assert property (cfg_rd |=> {rd_data_o[15:14], rd_data_o[7:0]} == 10'h000)
		else $error("reserved settings bits read nonzero");
	a_oneshot_read: assert property (hi_rd |=> rd_data_o == 16'h0000)
		else $error("write-only pointer read nonzero");
	a_pin_drive: assert property (alert_oe_o != alert_o)
		else $error("alert drive enable disagrees with level");
	a_conv_bound: assert property (run_len <= CONV_CYCLES)
		else $error("conversion ran too long");
	a_shut_abort: assert property (cfg_wr && wr_data_i[8] |-> ##[1:2] !conv_active_o)
		else $error("shutdown left conversion running");
	a_shut_alert: assert property (cfg_wr && wr_data_i[8] |-> ##4 alert_o == !$past(wr_data_i[10], 4))
		else $error("shutdown left alert active");
endmodule

bind tsr_sensor_bank tsr_bank_props #(.CONV_CYCLES(CONV_CYCLES)) props_u (
	.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .ptr_wr_i(ptr_wr_i), .ptr_data_i(ptr_data_i),
	.reg_wr_i(reg_wr_i), .wr_data_i(wr_data_i), .reg_rd_i(reg_rd_i), .rd_data_o(rd_data_o),
	.rd_valid_o(rd_valid_o), .conv_active_o(conv_active_o), .alert_o(alert_o),
	.alert_oe_o(alert_oe_o)
);

// ### testbench/tsr_host_model.sv
// Host model driving the register port of the sensor bank
`timescale 1ns/100ps
module tsr_host_model (
	input  wire logic        mclk_i,     // Clock
	input  wire logic [15:0] rd_data_i,  // Read word
	input  wire logic        rd_valid_i, // Read valid
	output logic             ptr_wr_o,   // Pointer strobe
	output logic [7:0]       ptr_data_o, // Pointer
	output logic             reg_wr_o,   // Write strobe
	output logic [15:0]      wr_data_o,  // Write word
	output logic             reg_rd_o    // Read strobe
);
	initial begin
		ptr_wr_o = 1'b0;
		ptr_data_o = 8'h00;
		reg_wr_o = 1'b0;
		wr_data_o = 16'h0000;
		reg_rd_o = 1'b0;
	end

	// Released buses show the inverse so stale values never pass
	task automatic write_word(input logic [7:0] ptr, input logic [15:0] data);
		@(negedge mclk_i);
		ptr_wr_o = 1'b1;
		ptr_data_o = ptr;
		reg_wr_o = 1'b1;
		wr_data_o = (ptr[2:0] == 3'h1) ? (data & 16'h3f00) : data;
		@(negedge mclk_i);
		ptr_wr_o = 1'b0;
		reg_wr_o = 1'b0;
		ptr_data_o = ~ptr_data_o;
		wr_data_o = ~wr_data_o;
	endtask

	task automatic read_word(input logic [7:0] ptr, output logic [15:0] data, output logic ok);
		@(negedge mclk_i);
		ptr_wr_o = 1'b1;
		ptr_data_o = ptr;
		reg_rd_o = 1'b1;
		@(negedge mclk_i);
		// Strobe was taken at the rising edge just passed; the answer stands until the next one
		data = rd_data_i;
		ok = rd_valid_i;
		ptr_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		ptr_data_o = ~ptr_data_o;
	endtask
endmodule

// ### testbench/tsr_sensor_bank_tb_top.sv
// Self-checking bench of the sensor register bank
`timescale 1ns/100ps
module tsr_sensor_bank_tb_top;
	localparam int         CONV  = 20;
	localparam int         PER   = 60;
	localparam logic [3:0] ABASE = 4'ha; // Arbitrary value
	logic        mclk_i;
	logic        rst_i;
	logic        ce_i;
	logic [2:0]  addr_pin_i;
	logic        ptr_wr_i;
	logic [7:0]  ptr_data_i;
	logic        reg_wr_i;
	logic [15:0] wr_data_i;
	logic        reg_rd_i;
	logic [11:0] sample_i;
	logic [15:0] rd_data_o;
	logic        rd_valid_o;
	logic [6:0]  dev_addr_o;
	logic        conv_active_o;
	logic        alert_o;
	logic        alert_oe_o;
	int          fails;
	int          n_tests;
	int          cycles;
	int          r;
	int          nq [4] = '{1, 2, 4, 6};

	tsr_sensor_bank #(.CONV_CYCLES(CONV), .PERIOD_CYCLES(PER), .ADDR_BASE(ABASE)) dut_u (
		.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_pin_i(addr_pin_i),
		.ptr_wr_i(ptr_wr_i), .ptr_data_i(ptr_data_i), .reg_wr_i(reg_wr_i),
		.wr_data_i(wr_data_i), .reg_rd_i(reg_rd_i), .sample_i(sample_i),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .dev_addr_o(dev_addr_o),
		.conv_active_o(conv_active_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o)
	);
	tsr_host_model host_u (
		.mclk_i(mclk_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o), .ptr_wr_o(ptr_wr_i),
		.ptr_data_o(ptr_data_i), .reg_wr_o(reg_wr_i), .wr_data_o(wr_data_i), .reg_rd_o(reg_rd_i)
	);

	task check(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task rd(input logic [7:0] ptr, input logic [15:0] exp, input string what);
		logic [15:0] w;
		logic        ok;
		host_u.read_word(ptr, w, ok);
		check({15'h0, ok}, 16'h0001, "read valid");
		check(w, exp, what);
	endtask

	task wr(input logic [7:0] ptr, input logic [15:0] data);
		host_u.write_word(ptr, data);
	endtask

	// Ends three cycles after a conversion finishes, when the alert has settled
	task wait_conv;
		int k;
		k = 0;
		while (conv_active_o !== 1'b1 && k < 2 * PER) begin @(negedge mclk_i); k++; end
		while (conv_active_o !== 1'b0 && k < 2 * PER) begin @(negedge mclk_i); k++; end
		repeat (3) @(negedge mclk_i);
		check({15'h0, k < 2 * PER}, 16'h0001, "conversion end");
	endtask

	task starts(input int cyc, output int n);
		logic prev;
		prev = conv_active_o;
		n = 0;
		repeat (cyc) begin
			@(negedge mclk_i);
			if (conv_active_o === 1'b1 && prev !== 1'b1) n++;
			prev = conv_active_o;
		end
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 12000) begin
			fails++;
			test_done;
		end
	end

	initial begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		addr_pin_i = 3'h5;
		sample_i = 12'h190;
		repeat (8) @(negedge mclk_i);
		rst_i = 1'b0;
		rd(8'h00, 16'h0000, "result reset");
		rd(8'h01, 16'h0000, "settings reset");
		rd(8'h02, 16'h4b00, "low reset");
		rd(8'h03, 16'h5000, "high reset");
		rd(8'h04, 16'h0000, "one-shot read");
		check({9'h0, dev_addr_o}, {9'h0, ABASE, 3'h5}, "bus address");
		wr(8'hfa, 16'h1a2f);
		rd(8'h02, 16'h1a20, "low limit");
		wr(8'h03, 16'h7ffe);
		rd(8'h03, 16'h7ff0, "high limit");
		wait_conv;
		wr(8'h00, 16'hffff);
		rd(8'h00, 16'h1900, "result");
		starts(PER + 2, r);
		check(16'(r), 16'h0001, "one start per period");
		while (conv_active_o !== 1'b1) @(negedge mclk_i);
		r = 0;
		while (conv_active_o !== 1'b0) @(negedge mclk_i);
		while (conv_active_o !== 1'b1) begin @(negedge mclk_i); r++; end
		check(16'(r), 16'(PER - CONV), "idle gap");
		wr(8'h02, 16'h1700);
		wr(8'h03, 16'h1800);
		for (int i = 0; i < 4; i++) begin
			wr(8'h01, {3'h0, 2'(i), 11'h000});
			sample_i = 12'h160;
			repeat (6) wait_conv;
			sample_i = 12'h190;
			for (int j = 1; j <= nq[i]; j++) begin
				wait_conv;
				check({15'h0, alert_o}, {15'h0, j != nq[i]}, "fault queue");
			end
		end
		wr(8'h01, 16'h0400);
		wait_conv;
		check({15'h0, alert_o}, 16'h0001, "high polarity");
		sample_i = 12'h170;
		wait_conv;
		check({15'h0, alert_o}, 16'h0001, "hysteresis hold");
		sample_i = 12'h160;
		wait_conv;
		check({15'h0, alert_o}, 16'h0000, "hysteresis release");
		wr(8'h01, 16'h0000);
		sample_i = 12'h190;
		wait_conv;
		check({15'h0, alert_o}, 16'h0000, "alert before shutdown");
		sample_i = 12'h100;
		while (conv_active_o !== 1'b1) @(negedge mclk_i);
		wr(8'h01, 16'h2100);
		repeat (4) @(negedge mclk_i);
		check({14'h0, alert_o, conv_active_o}, 16'h0002, "shutdown");
		rd(8'h00, 16'h1900, "aborted result");
		wr(8'h04, 16'h0000);
		check({15'h0, conv_active_o}, 16'h0000, "one-shot refused");
		starts(PER + 10, r);
		check(16'(r), 16'h0000, "one-shot in shutdown");
		wr(8'h01, 16'h2000);
		starts(PER + 10, r);
		check(16'(r), 16'h0000, "one-shot idle");
		wr(8'h04, 16'h00a5);
		check({15'h0, conv_active_o}, 16'h0001, "one-shot start");
		starts(2 * PER, r);
		check(16'(r), 16'h0000, "one-shot count");
		rd(8'h00, 16'h1000, "one-shot result");
		wr(8'h01, 16'h0000);
		starts(PER + 10, r);
		check({15'h0, r > 0}, 16'h0001, "continuous again");
		wr(8'h01, 16'h0200);
		sample_i = 12'h190;
		wait_conv;
		check({15'h0, alert_o}, 16'h0000, "interrupt set");
		wait_conv;
		check({15'h0, alert_o}, 16'h0000, "interrupt held");
		rd(8'h03, 16'h1800, "clearing read");
		repeat (3) @(negedge mclk_i);
		check({15'h0, alert_o}, 16'h0001, "interrupt cleared");
		wait_conv;
		check({15'h0, alert_o}, 16'h0001, "hunting low");
		sample_i = 12'h160;
		wait_conv;
		check({15'h0, alert_o}, 16'h0000, "interrupt on low");
		ce_i = 1'b0;
		addr_pin_i = 3'h2;
		repeat (6) @(negedge mclk_i);
		check({9'h0, dev_addr_o}, {9'h0, ABASE, 3'h5}, "enable freeze");
		ce_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		check({9'h0, dev_addr_o}, {9'h0, ABASE, 3'h2}, "strap follow");
		test_done;
	end
endmodule
